// ---- design/ocd_top.sv ----
// Purpose: clock divider pair outputs with axi4-lite registers
// Assumes: source clocks slower than aclk by at least four
// Notes:   source and sync pins pass three flops each
module ocd_top
    import ocd_pkg::*;
#(
    parameter int         ADDR_W  = 16,          // axi address width
    parameter logic [3:0] B_LOW   = RST_B_COUNT, // pair b low count
    parameter logic [3:0] B_HIGH  = RST_B_COUNT  // pair b high count
)
(
    input  wire logic              aclk,         // system clock
    input  wire logic              aresetn,      // sync reset, low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input  wire logic              s_axi_awvalid,// write addr valid
    output logic                   s_axi_awready,// write addr ready
    input  wire logic [31:0]       s_axi_wdata,  // write data
    input  wire logic [3:0]        s_axi_wstrb,  // byte enables
    input  wire logic              s_axi_wvalid, // write data valid
    output logic                   s_axi_wready, // write data ready
    output logic [1:0]             s_axi_bresp,  // write response
    output logic                   s_axi_bvalid, // response valid
    input  wire logic              s_axi_bready, // response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input  wire logic              s_axi_arvalid,// read addr valid
    output logic                   s_axi_arready,// read addr ready
    output logic [31:0]            s_axi_rdata,  // read data
    output logic [1:0]             s_axi_rresp,  // read response
    output logic                   s_axi_rvalid, // read valid
    input  wire logic              s_axi_rready, // read ready
    input  wire logic              vco_in,       // vco clock pin
    input  wire logic              ext_clk_in,   // external clock pin
    input  wire logic              sync_n_in,    // chip sync, low
    output logic                   pair_b_out_p, // pair b true
    output logic                   pair_b_out_n, // pair b complement
    output logic                   pair_c_out_p, // pair c true
    output logic                   pair_c_out_n  // pair c complement
);

    // synchroniser chain with accepted level
    typedef struct packed {
        logic [2:0] sh;  // shift stages
        logic       acc; // agreed level
    } ocd_pin_t;

    // whole module state
    typedef struct packed {
        logic [7:0]        b_route;  // pair b route and dcc
        logic [7:0]        c_count;  // pair c low and high
        logic [7:0]        c_ctrl;   // pair c control
        logic [7:0]        c_route;  // pair c route and dcc
        logic [1:0]        src_sel;  // source select
        logic              aw_have;  // write address held
        logic [ADDR_W-1:0] aw_addr;  // held write address
        logic              w_have;   // write data held
        logic [31:0]       w_data;   // held write data
        logic [3:0]        w_strb;   // held byte enables
        logic              bvalid;   // write response out
        logic [1:0]        bresp;    // write response code
        logic              rvalid;   // read data out
        logic [1:0]        rresp;    // read response code
        logic [31:0]       rdata;    // read data
        ocd_pin_t          vco;      // vco pin sync
        ocd_pin_t          ext;      // external pin sync
        ocd_pin_t          syn;      // sync pin sync
        logic              src_prev; // last divider source
        logic              syn_prev; // last sync level
        logic              b_p;      // pair b output
        logic              c_p;      // pair c output
    } ocd_st_t;

    ocd_st_t s_q, s_d;

    ocd_div_cfg_t cfg_b;       // pair b divider setup
    ocd_div_cfg_t cfg_c;       // pair c divider setup
    logic         div_b;       // pair b divided level
    logic         div_c;       // pair c divided level
    logic         src_lvl;     // divider input level
    logic         tick;        // divider input edge
    logic         sync_lvl;    // sync held active
    logic         sync_rise;   // sync released
    logic [11:0]  w_idx;       // write register index
    logic [11:0]  r_idx;       // read register index
    logic         w_fire;      // both write halves held
    logic         w_hit;       // write hits a register
    logic         w_bad;       // write refused
    logic [7:0]   wbyte;       // low byte of write data
    logic [7:0]   rbyte;       // low byte of read data
    logic         r_hit;       // read hits a register

    // pin synchroniser: second and third stage must agree
    function automatic ocd_pin_t pin_step(ocd_pin_t p, logic pin);
        ocd_pin_t n;
        n     = p;
        n.sh  = {p.sh[1:0], pin};
        if (p.sh[1] == p.sh[2])
            n.acc = p.sh[2];
        return n;
    endfunction

    // pair b uses fixed counts, register holds route and dcc
    always_comb
    begin
        cfg_b          = '0;
        cfg_b.low      = B_LOW;
        cfg_b.high     = B_HIGH;
        cfg_b.dcc_off  = s_q.b_route[DCC_BIT];
    end

    // pair c setup from its three registers
    always_comb
    begin
        cfg_c          = '0;
        cfg_c.bypass   = s_q.c_ctrl[BYPASS_BIT];
        cfg_c.nosync   = s_q.c_ctrl[NOSYNC_BIT];
        cfg_c.force_hi = s_q.c_ctrl[FORCE_BIT];
        cfg_c.start_hi = s_q.c_ctrl[START_BIT];
        cfg_c.phase    = s_q.c_ctrl[PHASE_MSB:PHASE_LSB];
        cfg_c.low      = s_q.c_count[LOW_MSB:LOW_LSB];
        cfg_c.high     = s_q.c_count[HIGH_MSB:HIGH_LSB];
        cfg_c.dcc_off  = s_q.c_route[DCC_BIT];
    end

    // divider input clock and sync events
    always_comb
    begin
        src_lvl   = s_q.src_sel[SEL_VCO] ? s_q.vco.acc : s_q.ext.acc;
        tick      = src_lvl && !s_q.src_prev;
        sync_lvl  = !s_q.syn.acc;
        sync_rise = s_q.syn.acc && !s_q.syn_prev;
    end

    // divider channel for pair b
    ocd_div_channel u_div_b
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .cfg       (cfg_b),
        .tick      (tick),
        .src_lvl   (src_lvl),
        .sync_lvl  (sync_lvl),
        .sync_rise (sync_rise),
        .div_out   (div_b)
    );

    // divider channel for pair c
    ocd_div_channel u_div_c
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .cfg       (cfg_c),
        .tick      (tick),
        .src_lvl   (src_lvl),
        .sync_lvl  (sync_lvl),
        .sync_rise (sync_rise),
        .div_out   (div_c)
    );

    // address decode and write checks
    always_comb
    begin
        w_idx  = s_q.aw_addr[13:2];
        r_idx  = s_axi_araddr[13:2];
        w_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        wbyte  = s_q.w_data[7:0];
        w_hit  = (w_idx == IDX_B_ROUTE) || (w_idx == IDX_C_COUNT)
              || (w_idx == IDX_C_CTRL)  || (w_idx == IDX_C_ROUTE)
              || (w_idx == IDX_SRC_SEL) || (w_idx == IDX_STATUS);
        // both select bits may not be set
        w_bad  = !w_hit || (s_q.aw_addr[ADDR_W-1:14] != '0)
              || ((w_idx == IDX_SRC_SEL) && wbyte[SEL_VCO]
                  && wbyte[SEL_BYP]);
    end

    // read mux, unused bits read zero
    always_comb
    begin
        rbyte = 8'h00;
        r_hit = s_axi_araddr[ADDR_W-1:14] == '0;
        if (r_idx == IDX_B_ROUTE)
            rbyte = s_q.b_route;
        else if (r_idx == IDX_C_COUNT)
            rbyte = s_q.c_count;
        else if (r_idx == IDX_C_CTRL)
            rbyte = s_q.c_ctrl;
        else if (r_idx == IDX_C_ROUTE)
            rbyte = s_q.c_route;
        else if (r_idx == IDX_SRC_SEL)
            rbyte = {6'h00, s_q.src_sel};
        else if (r_idx == IDX_STATUS)
            rbyte = {4'h0, sync_lvl, src_lvl, s_q.b_p, s_q.c_p};
        else
            r_hit = 1'b0;
    end

    // next state of the whole block
    always_comb
    begin
        s_d          = s_q;
        // pins through three flops
        s_d.vco      = pin_step(s_q.vco, vco_in);
        s_d.ext      = pin_step(s_q.ext, ext_clk_in);
        s_d.syn      = pin_step(s_q.syn, sync_n_in);
        s_d.src_prev = src_lvl;
        s_d.syn_prev = s_q.syn.acc;

        // write address channel
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        // write data channel
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        // both halves held: commit and answer
        if (w_fire)
        begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = w_bad ? RESP_SLVERR : RESP_OKAY;
            if (!w_bad && s_q.w_strb[0])
            begin
                if (w_idx == IDX_B_ROUTE)
                    s_d.b_route = wbyte;
                else if (w_idx == IDX_C_COUNT)
                    s_d.c_count = wbyte;
                else if (w_idx == IDX_C_CTRL)
                    s_d.c_ctrl = wbyte;
                else if (w_idx == IDX_C_ROUTE)
                    s_d.c_route = wbyte;
                else if (w_idx == IDX_SRC_SEL)
                    s_d.src_sel = wbyte[1:0];
            end
        end
        // response taken
        if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;

        // read: answer one cycle after address taken
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = {24'h000000, rbyte};
            s_d.rresp  = r_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_q.rvalid && s_axi_rready)
            s_d.rvalid = 1'b0;

        // pair b output select
        // direct bit with same coding
        if (s_q.b_route[DIRECT_BIT] && s_q.src_sel == 2'h2)
            s_d.b_p = s_q.vco.acc;
        else if (s_q.b_route[DIRECT_BIT] && s_q.src_sel == 2'h0)
            s_d.b_p = s_q.ext.acc;
        else
            s_d.b_p = div_b;

        // pair c output select
        // direct bit routes source
        if (s_q.c_route[DIRECT_BIT])
        begin
            // 10 vco, 00 ext, 01 divider
            unique case (s_q.src_sel)
                2'h2:    s_d.c_p = s_q.vco.acc;
                2'h0:    s_d.c_p = s_q.ext.acc;
                default: s_d.c_p = div_c;
            endcase
        end
        else
            s_d.c_p = div_c;
    end

    // state register with reset values
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q         <= '0;
            s_q.b_route <= RST_ROUTE;
            s_q.c_count <= RST_C_COUNT;
            s_q.c_ctrl  <= RST_C_CTRL;
            s_q.c_route <= RST_ROUTE;
            s_q.src_sel <= RST_SRC_SEL[1:0];
            s_q.syn.sh  <= 3'h7;
            s_q.syn.acc <= 1'b1;
            s_q.syn_prev <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // bus handshakes
    always_comb
    begin
        s_axi_awready = !s_q.aw_have;
        s_axi_wready  = !s_q.w_have;
        s_axi_arready = !s_q.rvalid;
    end

    // registered outputs
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp  = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rresp  = s_q.rresp;
    assign s_axi_rdata  = s_q.rdata;
    assign pair_b_out_p = s_q.b_p;
    assign pair_b_out_n = !s_q.b_p;
    assign pair_c_out_p = s_q.c_p;
    assign pair_c_out_n = !s_q.c_p;
endmodule

// ---- design/ocd_pkg.sv ----
// Purpose: constants and types for the output pair clock divider
// Assumes: axi4-lite slave, word index times four gives byte address
// Notes:   register indices, field positions and reset values below
package ocd_pkg;
    // register indices; byte address is index times four
    localparam logic [11:0] IDX_B_ROUTE  = 12'h195;
    localparam logic [11:0] IDX_C_COUNT  = 12'h196;
    localparam logic [11:0] IDX_C_CTRL   = 12'h197;
    localparam logic [11:0] IDX_C_ROUTE  = 12'h198;
    localparam logic [11:0] IDX_STATUS   = 12'h199;
    localparam logic [11:0] IDX_SRC_SEL  = 12'h1e1;
    // field positions
    localparam int LOW_MSB    = 7;
    localparam int LOW_LSB    = 4;
    localparam int HIGH_MSB   = 3;
    localparam int HIGH_LSB   = 0;
    localparam int BYPASS_BIT = 7;
    localparam int NOSYNC_BIT = 6;
    localparam int FORCE_BIT  = 5;
    localparam int START_BIT  = 4;
    localparam int PHASE_MSB  = 3;
    localparam int PHASE_LSB  = 0;
    localparam int DIRECT_BIT = 1;
    localparam int DCC_BIT    = 0;
    localparam int SEL_VCO    = 1;
    localparam int SEL_BYP    = 0;
    // reset values
    localparam logic [7:0] RST_C_COUNT = 8'h00;
    localparam logic [7:0] RST_C_CTRL  = 8'h00;
    localparam logic [7:0] RST_ROUTE   = 8'h00;
    localparam logic [7:0] RST_SRC_SEL = 8'h00;
    localparam logic [3:0] RST_B_COUNT = 4'hb;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // divider channel configuration
    typedef struct packed {
        logic       bypass;
        logic       nosync;
        logic       force_hi;
        logic       start_hi;
        logic [3:0] phase;
        logic [3:0] low;
        logic [3:0] high;
        logic       dcc_off;
    } ocd_div_cfg_t;
endpackage

// ---- design/ocd_div_channel.sv ----
// Purpose: one divider channel counting input clock cycles
// Assumes: tick marks one rising edge of the divider input clock
// Notes:   output is a registered level on aclk
module ocd_div_channel
    import ocd_pkg::*;
(
    input  wire logic          aclk,      // system clock
    input  wire logic          aresetn,   // sync reset, low
    input  wire ocd_pkg::ocd_div_cfg_t cfg, // channel setup
    input  wire logic          tick,      // input clock edge
    input  wire logic          src_lvl,   // input clock level
    input  wire logic          sync_lvl,  // accepted sync level
    input  wire logic          sync_rise, // sync release event
    output logic               div_out    // divided level
);
    typedef struct packed {
        logic [3:0] cnt;   // cycles left in phase
        logic [3:0] ph;    // phase offset left
        logic       lvl;   // divided level
        logic       out;   // output flop
    } ocd_ch_st_t;

    ocd_ch_st_t s_q, s_d;
    logic [4:0] total; // whole period minus two
    logic [3:0] hi_n;  // high count used
    logic [3:0] lo_n;  // low count used

    // duty-corrected counts when correction is on
    always_comb
    begin
        total = {1'b0, cfg.low} + {1'b0, cfg.high};
        if (!cfg.dcc_off)
        begin
            hi_n = total[4:1] + {3'h0, total[0]};
            lo_n = total[4:1];
        end
        else
        begin
            hi_n = cfg.high;
            lo_n = cfg.low;
        end
    end

    // next state
    always_comb
    begin
        s_d = s_q;
        if (!cfg.nosync && sync_lvl)
        begin
            s_d.lvl = cfg.start_hi;
            s_d.cnt = cfg.start_hi ? hi_n : lo_n;
            s_d.ph  = cfg.phase;
        end
        else if (!cfg.nosync && sync_rise)
        begin
            s_d.lvl = cfg.start_hi;
            s_d.cnt = cfg.start_hi ? hi_n : lo_n;
            s_d.ph  = cfg.phase;
        end
        else if (tick)
        begin
            if (s_q.ph != 4'h0)
                s_d.ph = s_q.ph - 4'h1;
            else if (s_q.cnt != 4'h0)
                s_d.cnt = s_q.cnt - 4'h1;
            else
            begin
                s_d.lvl = !s_q.lvl;
                s_d.cnt = s_q.lvl ? lo_n : hi_n;
            end
        end
        if (cfg.bypass)
            s_d.out = src_lvl;
        else if (cfg.nosync && sync_lvl)
            s_d.out = cfg.force_hi;
        else
            s_d.out = s_d.lvl;
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign div_out = s_q.out;
endmodule

// ---- dv/ocd_asserts.sv ----
// Purpose: bus and output checks on ocd_top ports
// Assumes: bench keeps sync off under bypass or direct route
// Notes:   bound to ocd_top at the foot of this file
module ocd_asserts (
    input wire logic       aclk,          // clock
    input wire logic       aresetn,       // sync reset, low
    input wire logic       s_axi_awvalid, // aw valid
    input wire logic       s_axi_awready, // aw ready
    input wire logic       s_axi_wvalid,  // w valid
    input wire logic       s_axi_wready,  // w ready
    input wire logic [1:0] s_axi_bresp,   // write response
    input wire logic       s_axi_bvalid,  // b valid
    input wire logic       s_axi_bready,  // b ready
    input wire logic       s_axi_arvalid, // ar valid
    input wire logic       s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata,  // read data
    input wire logic       s_axi_rvalid,  // r valid
    input wire logic       s_axi_rready,  // r ready
    input wire logic       sync_n_in,     // chip sync, low
    input wire logic       pair_b_out_p,  // pair b true
    input wire logic       pair_b_out_n,  // pair b complement
    input wire logic       pair_c_out_p,  // pair c true
    input wire logic       pair_c_out_n   // pair c complement
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_C_COMPL: assert property (pair_c_out_n != pair_c_out_p)
        else $error("pair c legs equal");
    AST_B_COMPL: assert property (pair_b_out_n != pair_b_out_p)
        else $error("pair b legs equal");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_W_ANS: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_BUSY: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid)
        else $error("read answer not released");
    AST_SYNC: assert property ((!sync_n_in)[*8] ##1 !sync_n_in
        |-> $stable(pair_c_out_p))
        else $error("pair c moved during sync");
    AST_RST: assert property (disable iff (1'b0) !aresetn
        |=> !pair_c_out_p && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not cleared by reset");
endmodule

bind ocd_top ocd_asserts ocd_asserts_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sync_n_in(sync_n_in), .pair_b_out_p(pair_b_out_p),
    .pair_b_out_n(pair_b_out_n), .pair_c_out_p(pair_c_out_p),
    .pair_c_out_n(pair_c_out_n)
);

// ---- dv/ocd_link_model.sv ----
// Purpose: source clocks and run length monitor of one pair
// Assumes: sources step on aclk edges, slower than aclk/8
// Notes:   after arm reports one full low run, then high run
module ocd_link_model #(
    parameter int VH = 8,  // vco half period in aclk
    parameter int EH = 12  // ext half period in aclk
) (
    input  wire logic   aclk,       // system clock
    input  wire logic   aresetn,    // sync reset, low
    input  wire logic   arm,        // start a measurement
    input  wire logic   pick,       // 1 watches pair b
    input  wire logic   pb,         // pair b true leg
    input  wire logic   pc,         // pair c true leg
    output logic        vco_in,     // vco source
    output logic        ext_clk_in, // external source
    output logic        meas_v,     // result strobe
    output logic [11:0] hi_len,     // high run length
    output logic [11:0] lo_len      // low run length
);
    logic [11:0] cnt; // cycles in current run
    logic [1:0]  st;  // idle, wait fall, low, high
    logic        pv;  // watched leg last cycle
    logic        p;   // watched leg
    int          vc;  // vco half period count
    int          ec;  // ext half period count
    assign p = pick ? pb : pc;
    // sources run free; runs timed edge to edge
    always @(posedge aclk)
    begin
        vc     <= (vc == VH - 1) ? 0 : vc + 1;
        ec     <= (ec == EH - 1) ? 0 : ec + 1;
        pv     <= p;
        cnt    <= cnt + 12'h001;
        meas_v <= 1'b0;
        if (vc == VH - 1) vco_in <= ~vco_in;
        if (ec == EH - 1) ext_clk_in <= ~ext_clk_in;
        case (st)
            2'h0: if (arm) st <= 2'h1;
            2'h1: if (pv && !p) {st, cnt} <= {2'h2, 12'h001};
            2'h2: if (!pv && p) {st, lo_len, cnt} <= {2'h3, cnt, 12'h001};
            default: if (pv && !p) {st, hi_len, meas_v} <= {2'h0, cnt, 1'b1};
        endcase
        if (!aresetn)
        begin
            {vc, ec, st} <= '0;
            {vco_in, ext_clk_in} <= 2'b00;
        end
    end
endmodule

// ---- dv/tb_top.sv ----
// Purpose: self checking bench for ocd_top
// Assumes: results pop from queues in issue order
// Notes:   wstrb tied to low byte
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] %0t result mismatch", $time); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ocd_pkg::*;
    localparam int VH = 8;      // vco half period
    localparam int EH = 12;     // ext half period
    localparam int T  = 2 * EH; // divider input period, ext
    logic        aclk, aresetn, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic        vco, ext, sync_n, bp, bn, cp, cn, arm, pick, peek;
    logic        meas_v;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [11:0] hi_len, lo_len;
    logic [33:0] bq[$];  // expected bus or level results
    logic [23:0] cq[$];  // expected high and low runs
    logic [7:0]  v;      // count value
    int          failures, num_checks, seed, i, r;
    logic [11:0] ri[5] = '{IDX_B_ROUTE, IDX_C_COUNT, IDX_C_CTRL,
                           IDX_C_ROUTE, IDX_SRC_SEL};
    logic [7:0]  sv[4] = '{8'h00, 8'h10, 8'h60, 8'h40}; // sync setups
    logic        sl[4] = '{1'b0, 1'b1, 1'b1, 1'b0};     // held level
    ocd_top #(.B_LOW(4'h1), .B_HIGH(4'h2)) ocd_top_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .vco_in(vco), .ext_clk_in(ext),
        .sync_n_in(sync_n), .pair_b_out_p(bp), .pair_b_out_n(bn),
        .pair_c_out_p(cp), .pair_c_out_n(cn));
    ocd_link_model #(.VH(VH), .EH(EH)) ocd_link_model_i (
        .aclk(aclk), .aresetn(aresetn), .arm(arm), .pick(pick), .pb(bp),
        .pc(cp), .vco_in(vco), .ext_clk_in(ext), .meas_v(meas_v),
        .hi_len(hi_len), .lo_len(lo_len));
    // clock source
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    // results against oldest notes
    always @(posedge aclk)
    begin
        if (bvalid && bready) `CHK({bresp, 32'h0}, bq.pop_front())
        if (rvalid && rready) `CHK({rresp, rdata}, bq.pop_front())
        if (peek) `CHK({33'h0, cp}, bq.pop_front())
        if (meas_v) `CHK({hi_len, lo_len}, cq.pop_front())
    end
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic stall();
        failures++;
        wrap_up();
    endtask
    // one write, response noted
    task automatic wr(input logic [11:0] x, input logic [7:0] d,
                      input logic [1:0] e = RESP_OKAY);
        int n;
        bq.push_back({e, 32'h0});
        {awaddr, wdata} <= {2'b0, x, 2'b0, 24'h0, d};
        {awvalid, wvalid, bready} <= 3'b111;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) stall();
        @(posedge aclk);
    endtask
    // one read, response and data noted
    task automatic rd(input logic [11:0] x, input logic [33:0] e);
        int n;
        bq.push_back(e);
        araddr <= {2'b0, x, 2'b0};
        {arvalid, rready} <= 2'b11;
        for (n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) stall();
        @(posedge aclk);
    endtask
    // settle, then time one low and one high run
    task automatic meas(input logic pk, input int hi, input int lo);
        int n;
        cq.push_back({hi[11:0], lo[11:0]});
        pick <= pk;
        repeat (700) @(posedge aclk);
        arm <= 1'b1;
        @(posedge aclk);
        arm <= 1'b0;
        for (n = 0; n < 4000 && !meas_v; n++) @(posedge aclk);
        if (n == 4000) stall();
    endtask
    // main sequence
    initial
    begin
        {failures, num_checks, seed} = {32'h0, 32'h0, 32'hfa35};
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, arm, pick, peek, sync_n} = '0;
        sync_n = 1'b1;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (ri[k]) rd(ri[k], {RESP_OKAY, 32'h0});
        wr(12'h1a0, 8'h55, RESP_SLVERR);
        rd(12'h1a0, {RESP_SLVERR, 32'h0});
        wr(IDX_SRC_SEL, 8'h03, RESP_SLVERR);
        rd(IDX_SRC_SEL, {RESP_OKAY, 32'h0});
        wr(IDX_C_ROUTE, 8'h01);
        for (i = 0; i < 4; i++)
        begin
            r = $random(seed);
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : r[7:0];
            wr(IDX_C_COUNT, v);
            rd(IDX_C_COUNT, {RESP_OKAY, 24'h0, v});
            meas(1'b0, (v[3:0] + 1) * T, (v[7:4] + 1) * T);
        end
        // duty correction: three high, two low
        wr(IDX_C_COUNT, 8'h30);
        wr(IDX_C_ROUTE, 8'h00);
        meas(1'b0, 3 * T, 2 * T);
        wr(IDX_C_CTRL, 8'h80);
        meas(1'b0, EH, EH);
        wr(IDX_C_CTRL, 8'he0);
        meas(1'b0, EH, EH);
        wr(IDX_C_CTRL, 8'h00);
        // direct routing per select code
        wr(IDX_C_ROUTE, 8'h03);
        wr(IDX_C_COUNT, 8'h11);
        wr(IDX_SRC_SEL, 8'h02);
        meas(1'b0, VH, VH);
        wr(IDX_SRC_SEL, 8'h00);
        meas(1'b0, EH, EH);
        wr(IDX_SRC_SEL, 8'h01);
        meas(1'b0, 2 * T, 2 * T);
        wr(IDX_B_ROUTE, 8'h02);
        wr(IDX_SRC_SEL, 8'h02);
        meas(1'b1, VH, VH);
        wr(IDX_B_ROUTE, 8'h00);
        meas(1'b1, 6 * VH, 4 * VH);
        wr(IDX_SRC_SEL, 8'h00);
        wr(IDX_C_ROUTE, 8'h01);
        // sync hold and forced levels
        for (i = 0; i < 4; i++)
        begin
            wr(IDX_C_CTRL, sv[i]);
            sync_n <= 1'b0;
            repeat (40) @(posedge aclk);
            bq.push_back({33'h0, sl[i]});
            peek <= 1'b1;
            @(posedge aclk);
            {peek, sync_n} <= 2'b01;
            repeat (20) @(posedge aclk);
        end
        meas(1'b0, 2 * T, 2 * T);
        wrap_up();
    end
endmodule
